// ===== src/dur_reg_decode.v
// Register decoder and register map for two serial channels on a parallel host bus.
`timescale 1ns/10ps
`include "dur_defines.vh"
module dur_reg_decode (
    input  wire        i_clk_sys,
    input  wire        i_rst_n,
    input  wire [2:0]  i_addr,
    input  wire        i_channel_one_select_n,
    input  wire        i_channel_two_select_n,
    input  wire        i_rd_n,
    input  wire        i_wr_n,
    input  wire [7:0]  i_wr_data,
    input  wire [15:0] i_rx_holding_byte,
    input  wire [15:0] i_line_state,
    input  wire [15:0] i_modem_inputs,
    input  wire [7:0]  i_int_code,
    output wire [7:0]  o_rd_data,
    output wire        o_rd_data_oe,
    output wire [15:0] o_tx_holding_byte,
    output wire [1:0]  o_tx_load,
    output wire [1:0]  o_rx_unload,
    output wire [1:0]  o_int_source_read,
    output wire [1:0]  o_line_state_read,
    output wire [1:0]  o_modem_inputs_read,
    output wire [31:0] o_baud_divisor,
    output wire [7:0]  o_interrupt_enables,
    output wire [15:0] o_line_format,
    output wire [9:0]  o_modem_outputs,
    output wire [1:0]  o_fifo_enable,
    output wire [1:0]  o_dma_mode,
    output wire [3:0]  o_rx_trigger,
    output wire [1:0]  o_rx_fifo_reset,
    output wire [1:0]  o_tx_fifo_reset
);
    // Strobes are levels; an access is taken once, on the cycle a strobe falls.
    reg        rd_n_prev_ff;
    reg        wr_n_prev_ff;
    reg        rd_pend_ff;
    reg        rd_ch_ff;
    reg [2:0]  rd_ofs_ff;
    reg [7:0]  rd_data_ff;
    reg        rd_oe_ff;

    reg [15:0] tx_byte_ff;
    reg [1:0]  tx_load_ff;
    reg [1:0]  rx_unload_ff;
    reg [1:0]  isrc_rd_ff;
    reg [1:0]  lsta_rd_ff;
    reg [1:0]  minp_rd_ff;
    reg [15:0] div_low_ff;
    reg [15:0] div_high_ff;
    reg [7:0]  iena_ff;
    reg [15:0] lfmt_ff;
    reg [9:0]  mout_ff;
    reg [1:0]  fifo_ena_ff;
    reg [1:0]  dma_ff;
    reg [3:0]  trig_ff;
    reg [1:0]  rx_rst_ff;
    reg [1:0]  tx_rst_ff;

    wire       any_sel;
    wire       ch;
    wire       rd_go;
    wire       wr_go;
    wire [7:0] scr_rd;
    wire       scr_wr;

    // Channel one wins if both selects are low, so one access never hits two sets.
    assign any_sel = ~i_channel_one_select_n | ~i_channel_two_select_n;
    assign ch      = i_channel_one_select_n;
    assign rd_go   = any_sel & ~i_rd_n & rd_n_prev_ff;
    assign wr_go   = any_sel & ~i_wr_n & wr_n_prev_ff;
    assign scr_wr  = wr_go & (i_addr == `DUR_OFS_SCR);

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_n_prev_ff <= 1'b1;
            wr_n_prev_ff <= 1'b1;
        end else begin
            rd_n_prev_ff <= i_rd_n;
            wr_n_prev_ff <= i_wr_n;
        end
    end

    // The scratch byte goes to its own store and touches nothing else.
    dur_scratch_mem u_scratch (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_wr_en   (scr_wr),
        .i_wr_addr (ch),
        .i_wr_data (i_wr_data),
        .i_rd_addr (ch),
        .o_rd_data (scr_rd)
    );

    genvar k;
    generate
        for (k = 0; k < `DUR_CHANNELS; k = k + 1) begin : g_chan
            wire hit_w;
            wire hit_r;
            wire dlab;
            assign hit_w = wr_go & (ch == k);
            assign hit_r = rd_go & (ch == k);
            assign dlab  = lfmt_ff[8*k+`DUR_LFMT_DLAB];

            always @(posedge i_clk_sys or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    tx_byte_ff[8*k+:8]  <= `DUR_RST_BYTE;
                    tx_load_ff[k]       <= 1'b0;
                    rx_unload_ff[k]     <= 1'b0;
                    isrc_rd_ff[k]       <= 1'b0;
                    lsta_rd_ff[k]       <= 1'b0;
                    minp_rd_ff[k]       <= 1'b0;
                    div_low_ff[8*k+:8]  <= `DUR_RST_BYTE;
                    div_high_ff[8*k+:8] <= `DUR_RST_BYTE;
                    iena_ff[4*k+:4]     <= `DUR_RST_IENA;
                    lfmt_ff[8*k+:8]     <= `DUR_RST_BYTE;
                    mout_ff[5*k+:5]     <= `DUR_RST_MOUT;
                    fifo_ena_ff[k]      <= 1'b0;
                    dma_ff[k]           <= 1'b0;
                    trig_ff[2*k+:2]     <= `DUR_RST_TRIG;
                    rx_rst_ff[k]        <= 1'b0;
                    tx_rst_ff[k]        <= 1'b0;
                end else begin
                    tx_load_ff[k]   <= 1'b0;
                    rx_rst_ff[k]    <= 1'b0;
                    tx_rst_ff[k]    <= 1'b0;
                    rx_unload_ff[k] <= hit_r & (i_addr == `DUR_OFS_DATA) & ~dlab;
                    isrc_rd_ff[k]   <= hit_r & (i_addr == `DUR_OFS_ISRC);
                    lsta_rd_ff[k]   <= hit_r & (i_addr == `DUR_OFS_LSTA);
                    minp_rd_ff[k]   <= hit_r & (i_addr == `DUR_OFS_MINP);
                    if (hit_w) begin
                        if (i_addr == `DUR_OFS_DATA && !dlab) begin
                            tx_byte_ff[8*k+:8] <= i_wr_data;
                            tx_load_ff[k]      <= 1'b1;
                        end else if (i_addr == `DUR_OFS_DATA) begin
                            div_low_ff[8*k+:8] <= i_wr_data;
                        end else if (i_addr == `DUR_OFS_IENA && dlab) begin
                            div_high_ff[8*k+:8] <= i_wr_data;
                        end else if (i_addr == `DUR_OFS_IENA) begin
                            iena_ff[4*k+:4] <= i_wr_data[3:0];
                        end else if (i_addr == `DUR_OFS_ISRC) begin
                            // Without the enable bit the other setup bits are dropped.
                            if (i_wr_data[`DUR_FCR_ENA]) begin
                                fifo_ena_ff[k]  <= 1'b1;
                                dma_ff[k]       <= i_wr_data[`DUR_FCR_DMA];
                                trig_ff[2*k+:2] <= i_wr_data[`DUR_FCR_TRIG_HI:`DUR_FCR_TRIG_LO];
                                rx_rst_ff[k]    <= i_wr_data[`DUR_FCR_RXRST];
                                tx_rst_ff[k]    <= i_wr_data[`DUR_FCR_TXRST];
                            end else begin
                                fifo_ena_ff[k] <= 1'b0;
                            end
                        end else if (i_addr == `DUR_OFS_LFMT) begin
                            lfmt_ff[8*k+:8] <= i_wr_data;
                        end else if (i_addr == `DUR_OFS_MOUT) begin
                            mout_ff[5*k+:5] <= i_wr_data[4:0];
                        end
                        // Offsets 5 and 6 are reserved on write and change nothing.
                    end
                end
            end
        end
    endgenerate

    // Reads take two edges: address capture with the store read, then the mux.
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_pend_ff <= 1'b0;
            rd_ch_ff   <= 1'b0;
            rd_ofs_ff  <= 3'h0;
        end else begin
            rd_pend_ff <= rd_go;
            if (rd_go) begin
                rd_ch_ff  <= ch;
                rd_ofs_ff <= i_addr;
            end
        end
    end

    reg [7:0] nxt_rd_data;
    reg       rd_dlab;
    always @* begin
        nxt_rd_data = 8'h00;
        rd_dlab     = lfmt_ff[8*rd_ch_ff+`DUR_LFMT_DLAB];
        if (rd_ofs_ff == `DUR_OFS_DATA && !rd_dlab) begin
            nxt_rd_data = i_rx_holding_byte[8*rd_ch_ff+:8];
        end else if (rd_ofs_ff == `DUR_OFS_DATA) begin
            nxt_rd_data = div_low_ff[8*rd_ch_ff+:8];
        end else if (rd_ofs_ff == `DUR_OFS_IENA && rd_dlab) begin
            nxt_rd_data = div_high_ff[8*rd_ch_ff+:8];
        end else if (rd_ofs_ff == `DUR_OFS_IENA) begin
            nxt_rd_data = {4'h0, iena_ff[4*rd_ch_ff+:4]};
        end else if (rd_ofs_ff == `DUR_OFS_ISRC) begin
            nxt_rd_data = {{2{fifo_ena_ff[rd_ch_ff]}}, `DUR_ISRC_PAD,
                           i_int_code[4*rd_ch_ff+:4]};
        end else if (rd_ofs_ff == `DUR_OFS_LFMT) begin
            nxt_rd_data = lfmt_ff[8*rd_ch_ff+:8];
        end else if (rd_ofs_ff == `DUR_OFS_MOUT) begin
            nxt_rd_data = {3'h0, mout_ff[5*rd_ch_ff+:5]};
        end else if (rd_ofs_ff == `DUR_OFS_LSTA) begin
            nxt_rd_data = i_line_state[8*rd_ch_ff+:8];
        end else if (rd_ofs_ff == `DUR_OFS_MINP) begin
            nxt_rd_data = i_modem_inputs[8*rd_ch_ff+:8];
        end else begin
            nxt_rd_data = scr_rd;
        end
    end

    // Data is driven only for an access that had a select, for as long as the strobe is low.
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_data_ff <= 8'h00;
            rd_oe_ff   <= 1'b0;
        end else begin
            if (rd_pend_ff) begin
                rd_data_ff <= nxt_rd_data;
                rd_oe_ff   <= 1'b1;
            end else if (i_rd_n) begin
                rd_oe_ff   <= 1'b0;
            end
        end
    end

    assign o_rd_data           = rd_data_ff;
    assign o_rd_data_oe        = rd_oe_ff;
    assign o_tx_holding_byte   = tx_byte_ff;
    assign o_tx_load           = tx_load_ff;
    assign o_rx_unload         = rx_unload_ff;
    assign o_int_source_read   = isrc_rd_ff;
    assign o_line_state_read   = lsta_rd_ff;
    assign o_modem_inputs_read = minp_rd_ff;
    assign o_baud_divisor      = {div_high_ff[15:8], div_low_ff[15:8],
                                  div_high_ff[7:0], div_low_ff[7:0]};
    assign o_interrupt_enables = iena_ff;
    assign o_line_format       = lfmt_ff;
    assign o_modem_outputs     = mout_ff;
    assign o_fifo_enable       = fifo_ena_ff;
    assign o_dma_mode          = dma_ff;
    assign o_rx_trigger        = trig_ff;
    assign o_rx_fifo_reset     = rx_rst_ff;
    assign o_tx_fifo_reset     = tx_rst_ff;
endmodule // dur_reg_decode

// ===== src/dur_defines.vh
// Constants and bit layout for the dual serial channel register decoder.
// Functional notes
// - Each channel has its own register set, chosen by its own chip select.
// - Offset 0, divisor bit clear: read gives receive byte, write loads transmit byte.
// - Offset 0, divisor bit set: access the low divisor byte.
// - Offset 1, divisor bit set: access the high divisor byte.
// - Offset 1, divisor bit clear: interrupt enables, upper four bits read zero.
// - Offset 2: read interrupt source, write FIFO setup, whatever the divisor bit.
// - Offset 3: line format register, always reachable, top bit banks offsets.
// - Offset 4: modem outputs register with loopback, interrupt gate, RTS, DTR.
// - Offset 5: read line state; writes change nothing.
// - Offset 6: read modem inputs, states high, change flags low; writes ignored.
// - Offset 7: eight-bit scratch byte for host use.
// - FIFO reset bits clear FIFO pointers only, then fall back to zero.
// - Interrupt source top two bits read one when FIFOs enabled, else zero.
`ifndef DUR_DEFINES_VH
`define DUR_DEFINES_VH
`define DUR_OFS_DATA      3'h0
`define DUR_OFS_IENA      3'h1
`define DUR_OFS_ISRC      3'h2
`define DUR_OFS_LFMT      3'h3
`define DUR_OFS_MOUT      3'h4
`define DUR_OFS_LSTA      3'h5
`define DUR_OFS_MINP      3'h6
`define DUR_OFS_SCR       3'h7
`define DUR_LFMT_DLAB     7
`define DUR_FCR_ENA       0
`define DUR_FCR_RXRST     1
`define DUR_FCR_TXRST     2
`define DUR_FCR_DMA       3
`define DUR_FCR_TRIG_HI   7
`define DUR_FCR_TRIG_LO   6
`define DUR_IENA_BITS     4
`define DUR_MOUT_BITS     5
`define DUR_RST_BYTE      8'h00
`define DUR_RST_IENA      4'h0
`define DUR_RST_MOUT      5'h00
`define DUR_RST_TRIG      2'h0
`define DUR_ISRC_PAD      2'h0
`define DUR_CHANNELS      2
`endif

// ===== src/dur_scratch_mem.v
// Small scratch byte store, one byte per channel, with registered read data.
`timescale 1ns/10ps
module dur_scratch_mem (
    input  wire       i_clk_sys,
    input  wire       i_rst_n,
    input  wire       i_wr_en,
    input  wire       i_wr_addr,
    input  wire [7:0] i_wr_data,
    input  wire       i_rd_addr,
    output wire [7:0] o_rd_data
);
    reg [7:0] mem_ff [0:1];
    reg [7:0] rd_data_ff;

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mem_ff[0]  <= 8'h00;
            mem_ff[1]  <= 8'h00;
            rd_data_ff <= 8'h00;
        end else begin
            if (i_wr_en) begin
                mem_ff[i_wr_addr] <= i_wr_data;
            end
            rd_data_ff <= mem_ff[i_rd_addr];
        end
    end

    assign o_rd_data = rd_data_ff;
endmodule // dur_scratch_mem

// ===== test/dur_reg_chk.sv
// Concurrent checks on the bus-facing ports of the register decoder.
`timescale 1ns/10ps
module dur_reg_chk (
    input wire logic        i_clk_sys,
    input wire logic        i_rst_n,
    input wire logic [2:0]  i_addr,
    input wire logic        i_channel_one_select_n,
    input wire logic        i_channel_two_select_n,
    input wire logic        i_rd_n,
    input wire logic        i_wr_n,
    input wire logic [7:0]  i_wr_data,
    input wire logic        o_rd_data_oe,
    input wire logic [15:0] o_tx_holding_byte,
    input wire logic [1:0]  o_tx_load,
    input wire logic [1:0]  o_rx_unload,
    input wire logic [1:0]  o_int_source_read,
    input wire logic [1:0]  o_modem_inputs_read,
    input wire logic [1:0]  o_tx_fifo_reset,
    input wire logic [1:0]  o_line_state_read,
    input wire logic [31:0] o_baud_divisor,
    input wire logic [7:0]  o_interrupt_enables,
    input wire logic [15:0] o_line_format,
    input wire logic [1:0]  o_rx_fifo_reset
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    wire        s1   = !i_channel_one_select_n;
    wire        none = i_channel_one_select_n && i_channel_two_select_n;
    wire        dlab = o_line_format[7];
    wire [55:0] cfg  = {o_baud_divisor, o_line_format, o_interrupt_enables};
    a_tx_load: assert property ($fell(i_wr_n) && s1 && i_addr == 3'h0 && !dlab
        |=> o_tx_load[0] && o_tx_holding_byte[7:0] == $past(i_wr_data)) else $error("tx load");
    a_div_low: assert property ($fell(i_wr_n) && s1 && i_addr == 3'h0 && dlab
        |=> o_baud_divisor[7:0] == $past(i_wr_data) && !o_tx_load[0]) else $error("div low");
    a_div_high: assert property ($fell(i_wr_n) && s1 && i_addr == 3'h1 && dlab
        |=> o_baud_divisor[15:8] == $past(i_wr_data)) else $error("div high");
    a_ier_write: assert property ($fell(i_wr_n) && s1 && i_addr == 3'h1 && !dlab
        |=> o_interrupt_enables[3:0] == $past(i_wr_data[3:0])) else $error("enables");
    a_fifo_reset: assert property ($fell(i_wr_n) && s1 && i_addr == 3'h2
        |=> o_rx_fifo_reset[0] == ($past(i_wr_data[1]) && $past(i_wr_data[0]))
        ##1 !o_rx_fifo_reset[0])
        else $error("fifo reset pulse");
    a_tx_fifo_rst: assert property ($fell(i_wr_n) && s1 && i_addr == 3'h2
        |=> o_tx_fifo_reset[0] == ($past(i_wr_data[2]) && $past(i_wr_data[0]))
        ##1 !o_tx_fifo_reset[0])
        else $error("tx fifo reset pulse");
    a_rx_unload: assert property ($fell(i_rd_n) && s1 && i_addr == 3'h0 && !dlab
        |=> o_rx_unload[0] ##1 !o_rx_unload[0]) else $error("receive unload pulse");
    a_src_read: assert property ($fell(i_rd_n) && s1 && i_addr == 3'h2
        |=> o_int_source_read[0] && !o_modem_inputs_read[0]) else $error("source read pulse");
    a_minp_read: assert property ($fell(i_rd_n) && s1 && i_addr == 3'h6
        |=> o_modem_inputs_read[0] && !o_int_source_read[0]) else $error("modem read pulse");
    a_lfmt_write: assert property ($fell(i_wr_n) && s1 && i_addr == 3'h3
        |=> o_line_format[7:0] == $past(i_wr_data)) else $error("line format");
    a_chan_two: assert property ($fell(i_wr_n) && !s1 && !none && i_addr == 3'h3
        |=> o_line_format == {$past(i_wr_data), $past(o_line_format[7:0])})
        else $error("channel two format");
    a_ro_write: assert property ($fell(i_wr_n) && s1 && i_addr >= 3'h5
        |=> $stable(cfg) && o_tx_load == 2'b00) else $error("write side effect");
    a_no_sel_wr: assert property ($fell(i_wr_n) && none |=> $stable(cfg))
        else $error("unselected write");
    a_no_sel_rd: assert property ($fell(i_rd_n) && none |=> !o_rd_data_oe [*3])
        else $error("unselected read drives");
    a_read_oe: assert property ($fell(i_rd_n) && !none ##1 !i_rd_n [*2]
        |-> ##[0:1] o_rd_data_oe) else $error("read data not driven");
    a_lsr_pulse: assert property ($fell(i_rd_n) && s1 && i_addr == 3'h5
        |=> o_line_state_read[0] ##1 !o_line_state_read[0]) else $error("status pulse");
    c_div: cover property ($fell(i_wr_n) && s1 && i_addr == 3'h0 && dlab);
    c_fifo: cover property ($fell(i_wr_n) && s1 && i_addr == 3'h2 && i_wr_data[1]);
    c_none: cover property ($fell(i_rd_n) && none);
endmodule // dur_reg_chk
bind dur_reg_decode dur_reg_chk u_chk (.i_clk_sys, .i_rst_n, .i_addr, .i_channel_one_select_n,
    .i_channel_two_select_n, .i_rd_n, .i_wr_n, .i_wr_data, .o_rd_data_oe, .o_tx_holding_byte,
    .o_tx_load, .o_rx_unload, .o_int_source_read, .o_modem_inputs_read, .o_tx_fifo_reset,
    .o_line_state_read, .o_baud_divisor, .o_interrupt_enables, .o_line_format,
    .o_rx_fifo_reset);

// ===== test/dur_host_model.sv
// Host processor model that runs reads and writes on the parallel register bus.
`timescale 1ns/10ps
module dur_host_model (
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_rd_data,
    output logic      [2:0] o_addr,
    output logic            o_sel_one_n,
    output logic            o_sel_two_n,
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic      [7:0] o_wr_data
);
    initial begin
        {o_addr, o_sel_one_n, o_sel_two_n, o_rd_n, o_wr_n, o_wr_data} = {3'h0, 4'hf, 8'h00};
    end
    // Bit 0 of ch selects channel one, bit 1 channel two; reads hold the strobe four edges.
    task automatic access(input logic [1:0] ch, input logic [2:0] ofs, input logic wr,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk_sys);
        o_addr <= ofs;
        o_sel_one_n <= ~ch[0];
        o_sel_two_n <= ~ch[1];
        o_wr_n <= ~wr;
        o_rd_n <= wr;
        o_wr_data <= d;
        repeat (wr ? 1 : 4) @(posedge i_clk_sys);
        q = i_rd_data;
        // Released address and data lines show inverted values so stale data cannot pass as fresh.
        o_addr <= ~ofs;
        o_sel_one_n <= 1'b1;
        o_sel_two_n <= 1'b1;
        o_wr_n <= 1'b1;
        o_rd_n <= 1'b1;
        o_wr_data <= ~d;
    endtask
endmodule // dur_host_model

// ===== test/test_dual_uart_register_decode.sv
// Self-checking bench for the dual channel register decoder.
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_dual_uart_register_decode;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic [15:0] i_rx_holding_byte = 16'h0000, i_line_state = 16'h0000;
    logic [15:0] i_modem_inputs = 16'h0000;
    logic [7:0] i_int_code = 8'h00;
    wire [2:0] i_addr;
    wire i_channel_one_select_n, i_channel_two_select_n, i_rd_n, i_wr_n, o_rd_data_oe;
    wire [7:0] i_wr_data, o_rd_data, o_interrupt_enables;
    wire [15:0] o_tx_holding_byte, o_line_format;
    wire [1:0] o_tx_load, o_rx_unload, o_int_source_read, o_line_state_read;
    wire [1:0] o_modem_inputs_read, o_fifo_enable, o_dma_mode, o_rx_fifo_reset, o_tx_fifo_reset;
    wire [31:0] o_baud_divisor;
    wire [9:0] o_modem_outputs;
    wire [3:0] o_rx_trigger;
    wire [7:0] bus = o_rd_data_oe ? o_rd_data : i_wr_data;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'h0001_4456;
    logic [2:0] rz [4] = '{3'h1, 3'h3, 3'h4, 3'h7};
    dur_reg_decode DUT (.i_clk_sys, .i_rst_n, .i_addr, .i_channel_one_select_n,
        .i_channel_two_select_n, .i_rd_n, .i_wr_n, .i_wr_data, .i_rx_holding_byte,
        .i_line_state, .i_modem_inputs, .i_int_code, .o_rd_data, .o_rd_data_oe,
        .o_tx_holding_byte, .o_tx_load, .o_rx_unload, .o_int_source_read, .o_line_state_read,
        .o_modem_inputs_read, .o_baud_divisor, .o_interrupt_enables, .o_line_format,
        .o_modem_outputs, .o_fifo_enable, .o_dma_mode, .o_rx_trigger, .o_rx_fifo_reset,
        .o_tx_fifo_reset);
    dur_host_model host (.i_clk_sys, .i_rd_data(bus), .o_addr(i_addr),
        .o_sel_one_n(i_channel_one_select_n), .o_sel_two_n(i_channel_two_select_n),
        .o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_wr_data(i_wr_data));
    always #12.5 i_clk_sys = ~i_clk_sys;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] isrc(input logic fe, input logic [3:0] code);
        return {fe, fe, 2'b00, code};
    endfunction
    task automatic wr(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.access(ch, a, 1'b1, d, q);
        // The task returns on the taking edge, so outputs are looked at half a cycle later.
        @(negedge i_clk_sys);
    endtask
    task automatic rd(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] e);
        logic [7:0] q;
        host.access(ch, a, 1'b0, 8'h00, q);
        `CHK(q, e)
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        logic [31:0] r;
        logic [7:0] lf, dl, dm, b, q;
        logic [7:0] sc [2];
        logic [1:0] c;
        int k, j;
        repeat (12) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        for (k = 0; k < 8; k++) rd(k < 4 ? 2'h1 : 2'h2, rz[k % 4], 8'h00);
        for (k = 0; k < 8; k++) begin
            j = k % 2;
            c = j ? 2'h2 : 2'h1;
            r = rnd();
            @(posedge i_clk_sys);
            i_rx_holding_byte <= r[15:0];
            i_line_state <= r[31:16];
            r = rnd();
            i_modem_inputs <= r[15:0];
            i_int_code <= r[23:16];
            dl = r[31:24];
            r = rnd();
            {b, lf, dm} = r[23:0];
            sc[j] = b;
            wr(c, 3'h3, lf | 8'h80);
            wr(c, 3'h0, dl);
            wr(c, 3'h1, dm);
            `CHK(o_baud_divisor[j*16 +: 16], {dm, dl})
            rd(c, 3'h0, dl);
            rd(c, 3'h1, dm);
            rd(c, 3'h3, lf | 8'h80);
            wr(c, 3'h3, lf & 8'h7f);
            wr(c, 3'h0, b);
            `CHK(o_tx_holding_byte[j*8 +: 8], b)
            rd(c, 3'h0, i_rx_holding_byte[j*8 +: 8]);
            wr(c, 3'h1, dl);
            rd(c, 3'h1, {4'h0, dl[3:0]});
            `CHK(o_baud_divisor[j*16 +: 16], {dm, dl})
            wr(c, 3'h2, {k[1:0], b[5:0]} | 8'h01);
            `CHK(o_rx_trigger[j*2 +: 2], k[1:0])
            `CHK(o_fifo_enable[j], 1'b1)
            `CHK(o_dma_mode[j], b[3])
            rd(c, 3'h2, isrc(1'b1, i_int_code[j*4 +: 4]));
            wr(c, 3'h2, ~b & 8'hfe);
            `CHK(o_fifo_enable[j], 1'b0)
            `CHK(o_dma_mode[j], b[3])
            `CHK(o_rx_trigger[j*2 +: 2], k[1:0])
            rd(c, 3'h2, isrc(1'b0, i_int_code[j*4 +: 4]));
            wr(c, 3'h4, dm);
            rd(c, 3'h4, {3'h0, dm[4:0]});
            `CHK(o_modem_outputs[j*5 +: 5], dm[4:0])
            wr(c, 3'h5, dl);
            wr(c, 3'h6, dl);
            rd(c, 3'h5, i_line_state[j*8 +: 8]);
            rd(c, 3'h6, i_modem_inputs[j*8 +: 8]);
            wr(c, 3'h7, b);
            rd(c, 3'h7, b);
            wr(2'h0, 3'h3, ~lf);
            host.access(2'h0, 3'h3, 1'b0, 8'h00, q);
            `CHK(o_rd_data_oe, 1'b0)
            `CHK(o_line_format[j*8 +: 8], lf & 8'h7f)
        end
        wr(2'h3, 3'h7, 8'h5a);
        rd(2'h1, 3'h7, 8'h5a);
        rd(2'h2, 3'h7, sc[1]);
        print_verdict();
    end
endmodule // test_dual_uart_register_decode
